// ===== rtl/rxmb_regs.vh
// constants for the rx manchester buffer control block
`ifndef RXMB_REGS_VH
`define RXMB_REGS_VH
`define RXMB_LIM_W        6
`define RXMB_CNT_W        8
`define RXMB_CNT_ZERO     8'h00
`define RXMB_CNT_ONE      8'h01
`define RXMB_BYTE_W       8
`define RXMB_BIT_LAST     3'h7
`define RXMB_BIT_ZERO     3'h0
`define RXMB_FILL_W       5
`define RXMB_FILL_ZERO    5'h00
`define RXMB_FILL_ONE     5'h01
`define RXMB_FILL_FULL    5'h10
`define RXMB_IDX_W        4
`define RXMB_IDX_ZERO     4'h0
`define RXMB_IDX_ONE      4'h1
`define RXMB_NCHK_W       2
`define RXMB_CHK_W        5
`define RXMB_CHK_ZERO     5'h00
`define RXMB_CHK_ONE      5'h01
`define RXMB_CHK_PER_SEL  5'h06
`define RXMB_IRQ_LVL1     5'h04
`define RXMB_IRQ_LVL2     5'h08
`define RXMB_IRQ_LVL3     5'h0c
`define RXMB_IRQ_LVL0     5'h01
`define RXMB_DIV_W        8
`define RXMB_DIV_ZERO     8'h00
`define RXMB_DIV_ONE      8'h01
`endif

// ===== rtl/rxmb_fifo.v
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module rxmb_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_sys_in,
    input  wire             rst_n_in,
    input  wire             clear_in,
    input  wire             wr_valid_in,
    output wire             wr_ready_out,
    input  wire [WIDTH-1:0] wr_data_in,
    output wire             rd_valid_out,
    input  wire             rd_ready_in,
    output wire [WIDTH-1:0] rd_data_out,
    output wire [AW:0]      fill_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp;
    reg [AW-1:0]    rp;
    reg [AW:0]      fill;
    wire            full  = (fill == DEPTH[AW:0]);
    wire            empty = (fill == {(AW+1){1'b0}});
    wire            do_rd = rd_ready_in && !empty;
    // writing when full pushes out the oldest word instead of stalling
    wire            do_wr = wr_valid_in;
    wire            drop  = do_wr && full && !do_rd;
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out  = mem[rp];
    assign fill_out     = fill;
    always @(posedge clk_sys_in) begin
        if (do_wr) begin
            mem[wp] <= wr_data_in;
        end
    end
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp   <= {AW{1'b0}};
            rp   <= {AW{1'b0}};
            fill <= {(AW+1){1'b0}};
        end else if (clear_in) begin
            wp   <= {AW{1'b0}};
            rp   <= {AW{1'b0}};
            fill <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wp <= wp + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_rd || drop) begin
                rp <= rp + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_wr && !do_rd && !full) begin
                fill <= fill + {{AW{1'b0}}, 1'b1};
            end else if (do_rd && !do_wr) begin
                fill <= fill - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/rxmb_core.v
// receive interval checker, manchester decoder and buffer control
`timescale 1ns/1ns
`default_nettype none
`include "rxmb_regs.vh"
module rxmb_core #(
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire                   clk_sys_in,
    input  wire                   rst_n_in,
    input  wire                   demod_in,
    input  wire                   decode_clk_en_in,
    input  wire                   startup_done_in,
    input  wire [`RXMB_LIM_W-1:0] lim_min_in,
    input  wire [`RXMB_LIM_W-1:0] lim_max_in,
    input  wire [`RXMB_NCHK_W-1:0] bit_check_sel_in,
    input  wire                   transparent_mode_in,
    input  wire                   pattern_mode_in,
    input  wire                   irq_level_bit0_in,
    input  wire                   irq_level_bit1_in,
    input  wire                   op_sel_bit0_in,
    input  wire                   op_sel_bit1_in,
    input  wire                   cfg_write_in,
    input  wire                   cs_n_in,
    input  wire                   byte_read_in,
    output reg  [`RXMB_BYTE_W-1:0] byte_data_out,
    output reg                    byte_valid_out,
    output reg  [`RXMB_FILL_W-1:0] rx_count_out,
    output reg                    serial_out_raw_rx_out,
    output reg                    supply_out_enable_out,
    output reg                    clock_out_enable_out,
    output reg                    irq_out,
    output reg                    receiving_out,
    output reg                    startup_out
);
    localparam ST_START = 2'b00;
    localparam ST_CHECK = 2'b01;
    localparam ST_SYNC  = 2'b10;
    localparam ST_DATA  = 2'b11;
    reg [1:0] state;
    reg       d_s1;
    reg       d_s2;
    reg       d_prev;
    reg [`RXMB_CNT_W-1:0] cv;
    reg [`RXMB_CHK_W-1:0] chk;
    reg       half;
    reg [`RXMB_BYTE_W-1:0] shreg;
    reg [2:0] bitn;
    reg       dclk_s1;
    reg       dclk_s2;
    reg       dclk_prev;
    reg       cs_n_s1;
    reg       cs_n_s2;
    reg [2:0] warm;
    // edges ignored until the chain holds real pin samples, else a false edge follows reset
    wire edge_seen = (d_s2 ^ d_prev) && warm[2];
    // decode clock arrives as a pin; its rising edge is the count enable
    wire dclk_tick = dclk_s2 && !dclk_prev && warm[2];
    // ceil((a+b) -/+ (b-a)/2) in integer form
    function [`RXMB_CNT_W-1:0] win2;
        input [`RXMB_LIM_W-1:0] a;
        input [`RXMB_LIM_W-1:0] b;
        input                   up;
        reg   [`RXMB_CNT_W:0]   s;
        reg   [`RXMB_CNT_W:0]   d;
        begin
            s = {3'b000, a} + {3'b000, b};
            d = {3'b000, b} - {3'b000, a};
            if (up) begin
                win2 = s[`RXMB_CNT_W-1:0] + d[`RXMB_CNT_W:1] + {7'h00, d[0]};
            end else begin
                win2 = s[`RXMB_CNT_W-1:0] - d[`RXMB_CNT_W:1];
            end
        end
    endfunction
    wire [`RXMB_CNT_W-1:0] double_window_low  = win2(lim_min_in, lim_max_in, 1'b0);
    wire [`RXMB_CNT_W-1:0] double_window_high = win2(lim_min_in, lim_max_in, 1'b1);
    wire [`RXMB_CNT_W-1:0] lmin = {2'b00, lim_min_in};
    wire [`RXMB_CNT_W-1:0] lmax = {2'b00, lim_max_in};
    // window is min <= cv < max, matching (max-1) as last good count
    wire is_t  = (cv >= lmin) && (cv < lmax);
    wire is_2t = (cv >= double_window_low) && (cv < double_window_high);
    wire [`RXMB_CHK_W-1:0] chk_need = {3'b000, bit_check_sel_in} * `RXMB_CHK_PER_SEL;
    reg  [`RXMB_FILL_W-1:0] lvl;
    always @* begin
        case ({irq_level_bit1_in, irq_level_bit0_in})
            2'b00:   lvl = `RXMB_IRQ_LVL0;
            2'b01:   lvl = `RXMB_IRQ_LVL1;
            2'b10:   lvl = `RXMB_IRQ_LVL2;
            default: lvl = `RXMB_IRQ_LVL3;
        endcase
    end
    reg        push;
    reg  [`RXMB_BYTE_W-1:0] push_data;
    wire       fifo_valid;
    wire [`RXMB_BYTE_W-1:0] fifo_data;
    wire [AW:0] fill;
    wire       buf_clear = cfg_write_in && receiving_out;
    wire       pop = byte_read_in && byte_valid_out;
    rxmb_fifo #(.WIDTH(`RXMB_BYTE_W), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .clear_in     (buf_clear),
        .wr_valid_in  (push),
        .wr_ready_out (),
        .wr_data_in   (push_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (pop),
        .rd_data_out  (fifo_data),
        .fill_out     (fill)
    );
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            d_s1 <= 1'b0;
            d_s2 <= 1'b0;
            d_prev <= 1'b0;
            dclk_s1 <= 1'b0;
            dclk_s2 <= 1'b0;
            dclk_prev <= 1'b0;
            cs_n_s1 <= 1'b1;
            cs_n_s2 <= 1'b1;
            warm <= 3'h0;
        end else begin
            d_s1 <= demod_in;
            d_s2 <= d_s1;
            d_prev <= d_s2;
            dclk_s1 <= decode_clk_en_in;
            dclk_s2 <= dclk_s1;
            dclk_prev <= dclk_s2;
            cs_n_s1 <= cs_n_in;
            cs_n_s2 <= cs_n_s1;
            warm <= {warm[1:0], 1'b1};
        end
    end
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_START;
            cv <= `RXMB_CNT_ZERO;
            chk <= `RXMB_CHK_ZERO;
            half <= 1'b0;
            shreg <= {`RXMB_BYTE_W{1'b0}};
            bitn <= `RXMB_BIT_ZERO;
            push <= 1'b0;
            push_data <= {`RXMB_BYTE_W{1'b0}};
            supply_out_enable_out <= 1'b0;
            clock_out_enable_out <= 1'b0;
            irq_out <= 1'b0;
            receiving_out <= 1'b0;
            startup_out <= 1'b1;
            serial_out_raw_rx_out <= 1'b0;
            byte_data_out <= {`RXMB_BYTE_W{1'b0}};
            byte_valid_out <= 1'b0;
            rx_count_out <= `RXMB_FILL_ZERO;
        end else begin
            push <= 1'b0;
            irq_out <= 1'b0;
            byte_valid_out <= fifo_valid && !pop && !buf_clear;
            byte_data_out <= fifo_data;
            rx_count_out <= fill;
            // raw stream only when transparent, receiving and chip select low
            if (!(transparent_mode_in && receiving_out && !cs_n_s2)) begin
                serial_out_raw_rx_out <= 1'b0;
            end else begin
                serial_out_raw_rx_out <= d_s2;
            end
            // a read in the same cycle keeps the count, so it is not counting up
            if (push && !pop && fill < DEPTH[AW:0] && fill + `RXMB_FILL_ONE == lvl) begin
                irq_out <= 1'b1;
            end
            if (dclk_tick && !edge_seen && cv != {`RXMB_CNT_W{1'b1}}) begin
                cv <= cv + `RXMB_CNT_ONE;
            end
            if (edge_seen) begin
                cv <= `RXMB_CNT_ZERO;
            end
            if (buf_clear) begin
                state <= (op_sel_bit0_in && op_sel_bit1_in) ? ST_START : state;
                startup_out <= op_sel_bit0_in && op_sel_bit1_in;
                receiving_out <= !(op_sel_bit0_in && op_sel_bit1_in);
                half <= 1'b0;
                bitn <= `RXMB_BIT_ZERO;
                cv <= `RXMB_CNT_ZERO;
            end else begin
                case (state)
                    ST_START: begin
                        chk <= `RXMB_CHK_ZERO;
                        if (startup_done_in) begin
                            state <= ST_CHECK;
                            startup_out <= 1'b0;
                            cv <= `RXMB_CNT_ZERO;
                        end
                    end
                    ST_CHECK: begin
                        if (chk >= chk_need) begin
                            state <= ST_SYNC;
                            receiving_out <= 1'b1;
                            supply_out_enable_out <= 1'b1;
                            clock_out_enable_out <= 1'b1;
                            irq_out <= !transparent_mode_in && !pattern_mode_in;
                            half <= 1'b0;
                        end else if ((edge_seen && !is_t) || cv >= lmax) begin
                            state <= ST_START;
                            startup_out <= 1'b1;
                        end else if (edge_seen) begin
                            chk <= chk + `RXMB_CHK_ONE;
                        end
                    end
                    ST_SYNC: begin
                        // preburst gives T edges; first 2T marks the start bit
                        if (edge_seen && is_2t) begin
                            shreg <= {shreg[6:0], d_s2};
                            bitn <= `RXMB_BIT_ZERO + 3'h1;
                            half <= 1'b0;
                            state <= ST_DATA;
                        end else if ((edge_seen && !is_t) || cv >= double_window_high) begin
                            irq_out <= 1'b1;
                            state <= ST_START;
                            startup_out <= 1'b1;
                            receiving_out <= 1'b0;
                        end
                    end
                    ST_DATA: begin
                        if ((edge_seen && !is_t && !is_2t) || cv >= double_window_high
                            || (edge_seen && is_2t && half)) begin
                            // partial byte dropped
                            irq_out <= 1'b1;
                            state <= ST_START;
                            startup_out <= 1'b1;
                            receiving_out <= 1'b0;
                            bitn <= `RXMB_BIT_ZERO;
                        end else if (edge_seen && is_t && !half) begin
                            half <= 1'b1;
                        end else if (edge_seen) begin
                            // centre edge: level after it is the bit
                            half <= 1'b0;
                            shreg <= {shreg[6:0], d_s2};
                            bitn <= bitn + 3'h1;
                            if (!transparent_mode_in && bitn == `RXMB_BIT_LAST) begin
                                push <= 1'b1;
                                push_data <= {shreg[6:0], d_s2};
                            end
                        end
                    end
                    default: state <= ST_START;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/rxmb_host_model.sv
// host model that fetches buffered bytes when enabled
`timescale 1ns/1ns
`default_nettype none
module rxmb_host_model (
    input  wire  clk_sys_in,
    input  wire  rst_n_in,
    input  wire  enable_in,
    input  wire  slow_in,
    input  wire  byte_valid_in,
    output logic byte_read_out
);
    logic [1:0] gap;
    // falling-edge drive keeps each pulse stable across one rising edge
    always @(negedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            byte_read_out <= 1'b0;
            gap           <= 2'h0;
        end else if (byte_read_out) begin
            byte_read_out <= 1'b0;
            gap           <= slow_in ? 2'h3 : 2'h0;
        end else if (gap != 2'h0) begin
            gap <= gap - 2'h1;
        end else begin
            byte_read_out <= enable_in && byte_valid_in;
        end
    end
endmodule
`default_nettype wire

// ===== dv/rxmb_core_chk.sv
// assertion checker for the receive buffer control core
`timescale 1ns/1ns
`default_nettype none
`include "rxmb_regs.vh"
module rxmb_core_chk (
    input wire                    clk_sys_in,
    input wire                    rst_n_in,
    input wire                    transparent_mode_in,
    input wire                    pattern_mode_in,
    input wire                    op_sel_bit0_in,
    input wire                    op_sel_bit1_in,
    input wire                    cfg_write_in,
    input wire                    cs_n_in,
    input wire [`RXMB_FILL_W-1:0] rx_count_out,
    input wire                    serial_out_raw_rx_out,
    input wire                    supply_out_enable_out,
    input wire                    clock_out_enable_out,
    input wire                    irq_out,
    input wire                    receiving_out,
    input wire                    startup_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    a_irq_single_pulse: assert property (irq_out |=> !irq_out)
        else $error("irq held longer than one cycle");
    a_fill_ceiling: assert property (rx_count_out <= `RXMB_FILL_FULL)
        else $error("fill count above buffer size");
    a_fill_unit_step: assert property ((rx_count_out != $past(rx_count_out)) |->
        (rx_count_out - $past(rx_count_out) == 5'h01 || $past(rx_count_out) - rx_count_out == 5'h01
        || rx_count_out == `RXMB_FILL_ZERO)) else $error("fill count jumped");
    a_entry_wakes_host: assert property ($rose(receiving_out) |-> ##[0:1]
        (supply_out_enable_out && clock_out_enable_out)) else $error("enables not set on entry");
    a_entry_irq_plain: assert property ($rose(receiving_out) && !transparent_mode_in &&
        !pattern_mode_in |-> ##[0:1] irq_out) else $error("no irq on receive entry");
    a_entry_irq_quiet: assert property ($rose(receiving_out) && transparent_mode_in |->
        !irq_out ##1 !irq_out) else $error("irq on transparent entry");
    // chip select passes two sync stages before it gates the registered pin
    a_raw_out_gating: assert property (serial_out_raw_rx_out |->
        $past(transparent_mode_in) && $past(receiving_out) && !$past(cs_n_in, 3))
        else $error("raw out while not allowed");
    a_cfg_clears_fill: assert property (receiving_out && cfg_write_in |->
        ##[1:3] rx_count_out == `RXMB_FILL_ZERO) else $error("config write kept fill count");
    a_cfg_restarts: assert property (receiving_out && cfg_write_in && op_sel_bit0_in &&
        op_sel_bit1_in |-> ##[1:2] startup_out) else $error("config write did not restart");
    a_single_state: assert property (!(receiving_out && startup_out))
        else $error("receiving and start-up together");
    c_entry: cover property ($rose(receiving_out));
    c_full: cover property (rx_count_out == `RXMB_FILL_FULL);
    c_cfg_rx: cover property (receiving_out && cfg_write_in);
endmodule
bind rxmb_core rxmb_core_chk i_rxmb_core_chk (.clk_sys_in, .rst_n_in, .transparent_mode_in, .pattern_mode_in,
    .op_sel_bit0_in, .op_sel_bit1_in, .cfg_write_in, .cs_n_in, .rx_count_out, .serial_out_raw_rx_out,
    .supply_out_enable_out, .clock_out_enable_out, .irq_out, .receiving_out, .startup_out);
`default_nettype wire

// ===== dv/test_rx_manchester_buffer_control.sv
// self-checking bench for the receive buffer control core
`timescale 1ns/1ns
`default_nettype none
`include "rxmb_regs.vh"
module test_rx_manchester_buffer_control;
    localparam int HALF = 120; // 15 decode ticks of 8 clocks: mid T window
    logic       clk_sys_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       demod_in = 1'b1;
    logic       decode_clk_en_in = 1'b0;
    logic [2:0] tick = 3'h0;
    logic       startup_done_in = 1'b1;
    logic [5:0] lim_min_in = 6'h0a;
    logic [5:0] lim_max_in = 6'h14;
    logic [1:0] bit_check_sel_in = 2'h1;
    logic       transparent_mode_in = 1'b0;
    logic       pattern_mode_in = 1'b0;
    logic       irq_level_bit0_in = 1'b0;
    logic       irq_level_bit1_in = 1'b0;
    logic       op_sel_bit0_in = 1'b1;
    logic       op_sel_bit1_in = 1'b1;
    logic       cfg_write_in = 1'b0;
    logic       cs_n_in = 1'b0;
    logic       host_en = 1'b0;
    logic       host_slow = 1'b0;
    wire        byte_read_in;
    wire  [7:0] byte_data_out;
    wire        byte_valid_out;
    wire  [4:0] rx_count_out;
    wire        serial_out_raw_rx_out;
    wire        supply_out_enable_out;
    wire        clock_out_enable_out;
    wire        irq_out;
    wire        receiving_out;
    wire        startup_out;
    int         fail_count = 0;
    int         tests_run = 0;
    int         irq_n = 0;
    logic [7:0] exp_q[$];
    logic [7:0] v;
    rxmb_core i_rxmb_core (.clk_sys_in, .rst_n_in, .demod_in, .decode_clk_en_in, .startup_done_in, .lim_min_in,
        .lim_max_in, .bit_check_sel_in, .transparent_mode_in, .pattern_mode_in, .irq_level_bit0_in,
        .irq_level_bit1_in, .op_sel_bit0_in, .op_sel_bit1_in, .cfg_write_in, .cs_n_in, .byte_read_in,
        .byte_data_out, .byte_valid_out, .rx_count_out, .serial_out_raw_rx_out, .supply_out_enable_out,
        .clock_out_enable_out, .irq_out, .receiving_out, .startup_out);
    rxmb_host_model i_rxmb_host_model (.clk_sys_in, .rst_n_in, .enable_in(host_en), .slow_in(host_slow),
        .byte_valid_in(byte_valid_out), .byte_read_out(byte_read_in));
    always #10 clk_sys_in = ~clk_sys_in;
    always @(negedge clk_sys_in) begin
        tick             <= tick + 3'h1;
        decode_clk_en_in <= tick[2]; // decode clock pin, square wave of eight clocks
    end
    always @(posedge clk_sys_in) if (irq_out === 1'b1) irq_n++;
    always @(posedge clk_sys_in) if (byte_read_in === 1'b1 && byte_valid_out === 1'b1)
        check("rx byte", byte_data_out, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task stop_test();
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic int lvl_of(input logic [1:0] s);
        return s == 2'h0 ? 1 : s == 2'h1 ? 4 : s == 2'h2 ? 8 : 12;
    endfunction
    task send_half(input logic l, input logic chk);
        demod_in = l;
        repeat (HALF / 2) @(negedge clk_sys_in);
        if (chk) check("raw out", serial_out_raw_rx_out, l);
        repeat (HALF / 2) @(negedge clk_sys_in);
    endtask
    // rising centre edge carries a one
    task send_byte(input logic [7:0] b, input logic chk);
        for (int i = 7; i >= 0; i--) begin
            send_half(!b[i], chk);
            send_half(b[i], chk);
        end
    endtask
    // all-zero preburst, long enough for the largest check count
    task preburst();
        repeat (12) begin
            send_half(1'b1, 1'b0);
            send_half(1'b0, 1'b0);
        end
    endtask
    initial begin
        void'($urandom(32'hcb2c_2474));
        repeat (8) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        bit_check_sel_in = 2'($urandom_range(3, 2));
        {irq_level_bit1_in, irq_level_bit0_in} = 2'($urandom_range(3, 0));
        preburst();
        for (int k = 1; k <= 18; k++) begin
            v = 8'($urandom) | (k == 1 ? 8'h80 : 8'h00); // start bit leads first byte
            exp_q.push_back(v);
            if (exp_q.size() > 16) void'(exp_q.pop_front());
            send_byte(v, 1'b0);
            check("fill", rx_count_out, 8'(k > 16 ? 16 : k));
            check("irq tally", 8'(irq_n), 8'(k >= lvl_of({irq_level_bit1_in, irq_level_bit0_in}) ? 2 : 1));
        end
        check("supply en", supply_out_enable_out, 1'b1);
        check("clock en", clock_out_enable_out, 1'b1);
        // seven good bits of one more byte, then silence: its centre edge never comes
        v = 8'($urandom);
        for (int i = 7; i > 0; i--) begin
            send_half(!v[i], 1'b0);
            send_half(v[i], 1'b0);
        end
        // start-up held so the restart stays visible instead of re-entering bit check
        startup_done_in = 1'b0;
        repeat (800) @(negedge clk_sys_in);
        check("error irq", 8'(irq_n), 8'h03);
        check("start-up", startup_out, 1'b1);
        check("rx after error", receiving_out, 1'b0);
        check("fill kept", rx_count_out, 8'h10);
        host_slow = 1'($urandom);
        host_en = 1'b1;
        repeat (200) @(negedge clk_sys_in);
        check("drained", rx_count_out, 8'h00);
        check("all read", 8'(exp_q.size()), 8'h00);
        host_en = 1'b0;
        pattern_mode_in = 1'b1;
        {irq_level_bit1_in, irq_level_bit0_in} = 2'h3;
        irq_n = 0;
        startup_done_in = 1'b1;
        preburst();
        for (int k = 1; k <= 3; k++) send_byte(8'($urandom) | (k == 1 ? 8'h80 : 8'h00), 1'b0);
        check("fill before cfg", rx_count_out, 8'h03);
        check("pattern irq", 8'(irq_n), 8'h00);
        check("receiving", receiving_out, 1'b1);
        startup_done_in = 1'b0;
        cfg_write_in = 1'b1;
        @(negedge clk_sys_in);
        cfg_write_in = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        check("cfg fill", rx_count_out, 8'h00);
        check("cfg valid", byte_valid_out, 1'b0);
        check("cfg start-up", startup_out, 1'b1);
        check("cfg receiving", receiving_out, 1'b0);
        pattern_mode_in = 1'b0;
        transparent_mode_in = 1'b1;
        startup_done_in = 1'b1;
        repeat (800) @(negedge clk_sys_in);
        irq_n = 0;
        preburst();
        send_byte(8'($urandom) | 8'h80, 1'b1);
        send_byte(8'($urandom), 1'b1);
        cs_n_in = 1'b1;
        repeat (10) @(negedge clk_sys_in);
        check("raw cs high", serial_out_raw_rx_out, 1'b0);
        check("transparent fill", rx_count_out, 8'h00);
        check("transparent irq", 8'(irq_n), 8'h00);
        stop_test();
    end
    // whole run is about 56,300 clocks; give up at 80,000
    initial begin
        #1_600_000;
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
